// ===== tmra_pkg.sv
package tmra_pkg;
  // register addresses in the control register space
  localparam logic [7:0] ADDR_CONTROL = 8'hE2;
  localparam logic [7:0] ADDR_PRESCALER = 8'hE3;
  localparam logic [7:0] ADDR_REF_DATA = 8'hE4;
  localparam logic [7:0] ADDR_COUNT = 8'hE5;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PRESCALER_RST = 8'h00;
  localparam logic [7:0] REF_DATA_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'h00;
  // control register field positions
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int CLEAR_BIT = 5;
  localparam int EDGE_BIT = 4;
  localparam int MC_IE_BIT = 3;
  localparam int OVF_IE_BIT = 2;
  localparam int MC_PEND_BIT = 1;
  localparam int OVF_PEND_BIT = 0;
  // clock source selections, prescaler bits 2:0
  localparam logic [2:0] CSEL_DIV1 = 3'h0;
  localparam logic [2:0] CSEL_DIV8 = 3'h1;
  localparam logic [2:0] CSEL_DIV64 = 3'h2;
  localparam logic [2:0] CSEL_DIV256 = 3'h3;
  localparam logic [2:0] CSEL_DIV1024 = 3'h4;
  localparam logic [2:0] CSEL_EXT = 3'h5;
  // divider timer_prescaler
  localparam int DIV_WIDTH = 10;
  localparam int TAP8 = 2;
  localparam int TAP64 = 5;
  localparam int TAP256 = 7;
  localparam int TAP1024 = 9;
  // capture pin route code in the port control field
  localparam logic [1:0] PORT_ROUTE_CAPTURE = 2'b00;
  // interrupt vectors of level zero
  localparam logic [7:0] VECTOR_OVERFLOW = 8'hD0;
  localparam logic [7:0] VECTOR_MATCH = 8'hCE;
  // operating modes
  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'b001,
    MODE_CAPTURE = 3'b010,
    MODE_PWM = 3'b100
  } mode_t;
endpackage : tmra_pkg

// ===== edge_sync.sv
// two-flop synchroniser with rising and falling edge pulses
module edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r; // first stage, read only by the second
  logic sync_r; // second stage
  logic last_r; // previous synced level for edges

  // synchroniser chain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce_i) begin
      meta_r <= d_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign q_o = sync_r;
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;
endmodule : edge_sync

// ===== tmra_timer.sv
module tmra_timer
  import tmra_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // port low-byte control bits 7:6 from port block
  input wire logic [1:0] PORT_ROUTE_I,
  // interrupt acknowledge of the overflow vector
  input wire logic OVF_ACK_I,
  // pins
  input wire logic EXT_CLK_PIN_I,
  input wire logic CAPTURE_PIN_I,
  output logic OUTPUT_PIN_O,
  // interrupt requests at level zero
  output logic OVF_IRQ_O,
  output logic MC_IRQ_O,
  output logic [7:0] IRQ_VECTOR_O
);
  logic [7:0] control_r; // control register
  logic [7:0] prescaler_r; // prescaler register
  logic [7:0] ref_data_r; // reference / capture data
  logic [7:0] count_r; // up-counter
  logic [DIV_WIDTH-1:0] div_r; // free system clock divider
  logic [DIV_WIDTH-1:0] div_nxt; // divider next value
  logic [DIV_WIDTH-1:0] div_last_r; // divider previous value
  logic out_r; // output pin level
  logic [7:0] rdata_r; // read data
  logic ovf_irq_r; // overflow request
  logic mc_irq_r; // match request
  logic [7:0] vec_r; // vector for the pending request
  logic ext_rise; // synced external clock edge
  logic cap_rise; // synced capture rising edge
  logic cap_fall; // synced capture falling edge
  logic tick; // counter clock enable
  logic match; // comparator result
  logic cap_evt; // capture trigger
  logic ovf_evt; // count wrap
  logic wr_ctl; // control write strobe
  logic wr_ps; // prescaler write strobe
  logic wr_data; // reference write strobe
  mode_t mode; // decoded mode

  // external clock pin synchroniser
  edge_sync u_ext_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .d_i(EXT_CLK_PIN_I),
    .q_o(),
    .rise_o(ext_rise),
    .fall_o()
  );

  // capture pin synchroniser
  edge_sync u_cap_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .d_i(CAPTURE_PIN_I),
    .q_o(),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // write strobes
  assign wr_ctl = REG_WR_I && (REG_ADDR_I == ADDR_CONTROL);
  assign wr_ps = REG_WR_I && (REG_ADDR_I == ADDR_PRESCALER);
  assign wr_data = REG_WR_I && (REG_ADDR_I == ADDR_REF_DATA);

  // mode decode; code 11 acts as interval
  always_comb begin
    unique case (control_r[MODE_HI:MODE_LO])
      2'b01: mode = MODE_CAPTURE;
      2'b10: mode = MODE_PWM;
      default: mode = MODE_INTERVAL;
    endcase
  end

  // divider runs freely on the system clock
  assign div_nxt = div_r + {{(DIV_WIDTH-1){1'b0}}, 1'b1};

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_r <= '0;
      div_last_r <= '0;
    end else if (CE_I) begin
      div_r <= div_nxt;
      div_last_r <= div_r;
    end
  end

  // clock source mux: falling edge of a divider bit is one tick
  always_comb begin
    unique case (prescaler_r[2:0])
      CSEL_DIV1: tick = 1'b1;
      CSEL_DIV8: tick = div_last_r[TAP8] & ~div_r[TAP8];
      CSEL_DIV64: tick = div_last_r[TAP64] & ~div_r[TAP64];
      CSEL_DIV256: tick = div_last_r[TAP256] & ~div_r[TAP256];
      CSEL_DIV1024: tick = div_last_r[TAP1024] & ~div_r[TAP1024];
      CSEL_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // comparator and events
  assign match = tick && (count_r == ref_data_r);
  assign ovf_evt = tick && (count_r == 8'hFF) &&
                   !(mode == MODE_INTERVAL && match);
  // capture pin only when routed by the port control
  assign cap_evt = (mode == MODE_CAPTURE) &&
                   (PORT_ROUTE_I == PORT_ROUTE_CAPTURE) &&
                   (control_r[EDGE_BIT] ? cap_rise : cap_fall);

  // counter
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      count_r <= COUNT_RST;
    end else if (CE_I) begin
      if (wr_ctl && REG_WDATA_I[CLEAR_BIT]) begin
        count_r <= COUNT_RST;
      end else if (mode == MODE_INTERVAL && match) begin
        count_r <= COUNT_RST;
      end else if (tick) begin
        count_r <= count_r + 8'h01; // wraps FF to 00
      end
    end
  end

  // reference data: software write or capture load
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ref_data_r <= REF_DATA_RST;
    end else if (CE_I) begin
      if (cap_evt) begin
        ref_data_r <= count_r;
      end else if (wr_data) begin
        ref_data_r <= REG_WDATA_I;
      end
    end
  end

  // control register with sticky pending bits; set beats clear
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      control_r <= CONTROL_RST;
    end else if (CE_I) begin
      if (wr_ctl) begin
        control_r[7:2] <= {REG_WDATA_I[7:6], 1'b0, REG_WDATA_I[4:2]};
        // a write clears a pending bit only where its data bit is zero
        control_r[MC_PEND_BIT] <= control_r[MC_PEND_BIT] &
                                  REG_WDATA_I[MC_PEND_BIT];
        control_r[OVF_PEND_BIT] <= control_r[OVF_PEND_BIT] &
                                   REG_WDATA_I[OVF_PEND_BIT];
      end else if (OVF_ACK_I) begin
        control_r[OVF_PEND_BIT] <= 1'b0;
      end
      // interval match, pwm match, or capture load
      if ((match && mode != MODE_CAPTURE) || cap_evt) begin
        control_r[MC_PEND_BIT] <= 1'b1;
      end
      if (ovf_evt) begin
        control_r[OVF_PEND_BIT] <= 1'b1;
      end
    end
  end

  // prescaler register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prescaler_r <= PRESCALER_RST;
    end else if (CE_I && wr_ps) begin
      prescaler_r <= REG_WDATA_I;
    end
  end

  // output pin: toggle in interval, compare in pwm
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      out_r <= 1'b0;
    end else if (CE_I) begin
      unique case (mode)
        MODE_INTERVAL: begin
          if (match) begin
            out_r <= ~out_r;
          end
        end
        MODE_PWM: begin
          // period of 256 ticks since counter wraps
          out_r <= (ref_data_r > count_r);
        end
        MODE_CAPTURE: begin
          out_r <= out_r; // pin idle
        end
      endcase
    end
  end

  // interrupt requests, gated by enables; match has priority vector
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ovf_irq_r <= 1'b0;
      mc_irq_r <= 1'b0;
      vec_r <= 8'h00;
    end else if (CE_I) begin
      ovf_irq_r <= control_r[OVF_PEND_BIT] & control_r[OVF_IE_BIT];
      mc_irq_r <= control_r[MC_PEND_BIT] & control_r[MC_IE_BIT];
      if (control_r[MC_PEND_BIT] & control_r[MC_IE_BIT]) begin
        vec_r <= VECTOR_MATCH;
      end else if (control_r[OVF_PEND_BIT] & control_r[OVF_IE_BIT]) begin
        vec_r <= VECTOR_OVERFLOW;
      end else begin
        vec_r <= 8'h00;
      end
    end
  end

  // registered read data; unmapped reads return zero
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_r <= 8'h00;
    end else if (CE_I) begin
      if (REG_RD_I) begin
        unique case (REG_ADDR_I)
          ADDR_CONTROL: rdata_r <= control_r;
          ADDR_PRESCALER: rdata_r <= prescaler_r;
          ADDR_REF_DATA: rdata_r <= ref_data_r;
          ADDR_COUNT: rdata_r <= count_r;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA_O = rdata_r;
  assign OUTPUT_PIN_O = out_r;
  assign OVF_IRQ_O = ovf_irq_r;
  assign MC_IRQ_O = mc_irq_r;
  assign IRQ_VECTOR_O = vec_r;
endmodule : tmra_timer

// ===== tmra_checker.sv
module tmra_checker
  import tmra_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  // pins and requests
  input wire logic OVF_ACK_I,
  input wire logic OUTPUT_PIN_O,
  input wire logic OVF_IRQ_O,
  input wire logic MC_IRQ_O,
  input wire logic [7:0] IRQ_VECTOR_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [7:0] ctl_r; // last written control value
  wire ctl_wr = CE_I && REG_WR_I && REG_ADDR_I == ADDR_CONTROL;
  // shadow of the control writes
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) ctl_r <= 8'h00;
    else if (ctl_wr) ctl_r <= REG_WDATA_I;
  end
  a_vector_match: assert property (
    MC_IRQ_O |-> IRQ_VECTOR_O == VECTOR_MATCH) else $error("bad vector");
  a_vector_ovf: assert property (
    OVF_IRQ_O && !MC_IRQ_O |-> IRQ_VECTOR_O == VECTOR_OVERFLOW)
    else $error("bad vector");
  a_mc_enable: assert property (
    MC_IRQ_O |-> $past(ctl_r[3])) else $error("match request masked");
  a_ovf_enable: assert property (
    OVF_IRQ_O |-> $past(ctl_r[2])) else $error("overflow request masked");
  a_mc_hold: assert property (
    $fell(MC_IRQ_O) |-> $past(ctl_wr, 2)) else $error("match dropped");
  a_ack_clear: assert property (
    CE_I && OVF_ACK_I && !REG_WR_I ##1 CE_I |-> ##1 !OVF_IRQ_O)
    else $error("ack ignored");
  a_read_clear: assert property (
    CE_I && REG_RD_I && REG_ADDR_I == ADDR_CONTROL |=> !REG_RDATA_O[5])
    else $error("clear bit reads one");
  a_toggle_irq: assert property (
    $changed(OUTPUT_PIN_O) && ctl_r[7] == ctl_r[6] && ctl_r[3]
    && $stable(ctl_r) |-> ##[1:3] MC_IRQ_O) else $error("toggle no irq");
endmodule : tmra_checker

bind tmra_timer tmra_checker chk (.CLK_I, .SYS_RST_I, .CE_I, .REG_ADDR_I,
  .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .OVF_ACK_I,
  .OUTPUT_PIN_O, .OVF_IRQ_O, .MC_IRQ_O, .IRQ_VECTOR_O);

// ===== tmra_pins.sv
// far side: external clock and capture lines
module tmra_pins (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic cap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines idle low, clock still outside bursts
  initial begin
    ext_clk_o = 1'b0;
    cap_o = 1'b0;
  end
  // burst of slow pulses the two-flop sync can see
  task automatic clocks(input int n);
    repeat (n) begin
      repeat (3) @(negedge clk_i);
      ext_clk_o = 1'b1;
      repeat (3) @(negedge clk_i);
      ext_clk_o = 1'b0;
    end
  endtask : clocks
  // move the capture line, then let the sync settle
  task automatic edge_to(input logic v);
    @(negedge clk_i);
    cap_o = v;
    repeat (6) @(negedge clk_i);
  endtask : edge_to
endmodule : tmra_pins

// ===== tb.sv
module tb;
  import tmra_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vec, v;
  logic [1:0] route = 2'b00;
  logic ce = 1'b1;
  logic [7:0] a0;
  logic pin, ovf, mc, ext, cap;
  int miscompares = 0, samples_checked = 0, seed = 55259, n, g;
  int dv[4] = '{8, 64, 256, 1024};
  always #5 clk = ~clk;
  tmra_timer uut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .PORT_ROUTE_I(route), .OVF_ACK_I(ack),
    .EXT_CLK_PIN_I(ext), .CAPTURE_PIN_I(cap), .OUTPUT_PIN_O(pin),
    .OVF_IRQ_O(ovf), .MC_IRQ_O(mc), .IRQ_VECTOR_O(vec));
  tmra_pins pins (.clk_i(clk), .ext_clk_o(ext), .cap_o(cap));
  // compare one result
  task automatic check(input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // register write and read cycles
  task automatic wreg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask : rreg
  // cycles until the output pin changes
  task automatic pin_gap;
    logic p;
    g = 0;
    p = pin;
    while (pin === p && g < 600) begin
      @(negedge clk);
      g++;
    end
  endtask : pin_gap
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // hang guard
  initial begin
    #600000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rreg(ADDR_CONTROL);
    check(v, 8'h00);
    rreg(8'h10);
    check(v, 8'h00);
    n = $random(seed);
    wreg(ADDR_PRESCALER, n[7:0] & 8'hF8);
    rreg(ADDR_PRESCALER);
    check(v, n[7:0] & 8'hF8);
    // interval mode: toggle period and match pending
    n = 3 + ($unsigned($random(seed)) % 13);
    wreg(ADDR_REF_DATA, n[7:0]);
    wreg(ADDR_CONTROL, 8'h28);
    pin_gap();
    pin_gap();
    check(8'(g), 8'(n + 1));
    check(8'(mc), 8'h01);
    check(vec, VECTOR_MATCH);
    repeat (20) begin
      rreg(ADDR_COUNT);
      check(8'(v <= n), 8'h01);
    end
    wreg(ADDR_PRESCALER, 8'h06);
    rreg(ADDR_CONTROL);
    check(v, 8'h0A);
    wreg(ADDR_CONTROL, 8'h08);
    rreg(ADDR_CONTROL);
    check(v, 8'h08);
    check(8'(mc), 8'h00);
    // divided clocks: about twenty ticks each
    wreg(ADDR_REF_DATA, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      wreg(ADDR_PRESCALER, 8'(k + 1));
      wreg(ADDR_CONTROL, 8'h20);
      repeat (20 * dv[k]) @(negedge clk);
      rreg(ADDR_COUNT);
      check(8'(v >= 19 && v <= 21), 8'h01);
    end
    // pwm duty over two periods, then overflow
    n = 1 + ($unsigned($random(seed)) % 254);
    wreg(ADDR_PRESCALER, 8'h00);
    wreg(ADDR_REF_DATA, n[7:0]);
    wreg(ADDR_CONTROL, 8'hA0);
    g = 0;
    repeat (512) begin
      @(negedge clk);
      g += int'(pin === 1'b1);
    end
    check(8'(g / 2), n[7:0]);
    // clock enable low freezes the free running count
    rreg(ADDR_COUNT);
    a0 = v;
    ce = 1'b0;
    repeat (3 + ($unsigned($random(seed)) % 20)) @(negedge clk);
    ce = 1'b1;
    rreg(ADDR_COUNT);
    check(v, 8'(a0 + 8'h02));
    wreg(ADDR_CONTROL, 8'hA4);
    pin_gap();
    repeat (300) if (ovf !== 1'b1) @(negedge clk);
    check(8'(ovf), 8'h01);
    check(vec, VECTOR_OVERFLOW);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
    check(8'(ovf), 8'h00);
    // capture on external clock counts
    n = 1 + ($unsigned($random(seed)) % 40);
    wreg(ADDR_PRESCALER, 8'h05);
    wreg(ADDR_CONTROL, 8'h78);
    pins.clocks(n);
    pins.edge_to(1'b1);
    check(8'(mc), 8'h01);
    rreg(ADDR_REF_DATA);
    check(v, n[7:0]);
    wreg(ADDR_CONTROL, 8'h58);
    route = 2'b01;
    pins.clocks(2);
    pins.edge_to(1'b0);
    pins.edge_to(1'b1);
    rreg(ADDR_REF_DATA);
    check(v, n[7:0]);
    route = 2'b00;
    wreg(ADDR_CONTROL, 8'h48);
    pins.edge_to(1'b0);
    rreg(ADDR_REF_DATA);
    check(v, 8'(n + 2));
    final_report();
  end
endmodule : tb
